// >>> verilog/cfg_bank_pkg.sv
package cfg_bank_pkg;
   // ********************************************************
   // register offsets
   // ********************************************************
   localparam logic [7:0] OFS_WATCHDOG_DISABLE   = 8'h1C;
   localparam logic [7:0] OFS_DSP_START_PIN      = 8'h1D;
   localparam logic [7:0] OFS_IRQ_ROUTE_TRIGGER  = 8'h1E;
   localparam logic [7:0] OFS_PULSE_OUT0_CONFIG  = 8'h1F;
   localparam logic [7:0] OFS_PULSE_OUT1_CONFIG  = 8'h20;
   localparam logic [7:0] OFS_PORT_DIR_PULLUP    = 8'h21;
   localparam logic [7:0] OFS_BANDGAP_POWER_ON_CONVERT  = 8'h22;
   localparam logic [7:0] OFS_GAIN_CORRECTION    = 8'h23;
   localparam logic [7:0] OFS_UNUSED_SLOT        = 8'h24;

   // ********************************************************
   // reset values and key codes
   // ********************************************************
   localparam logic [7:0] RST_ZERO               = 8'h00;
   localparam logic [7:0] RST_BANDGAP_POWER_ON_CONVERT  = 8'h07;
   localparam logic [7:0] RST_GAIN_CORRECTION    = 8'h40;
   localparam logic [7:0] WATCHDOG_OFF_KEY       = 8'h5A;

   // ********************************************************
   // field positions
   // ********************************************************
   localparam int         F_HI_NIB_LSB           = 4;
   localparam int         F_IRQ_TO_PIN5          = 7;
   localparam int         F_IRQ_TO_PIN4          = 6;
   localparam int         F_TRIG_CAP             = 0;
   localparam int         F_TRIG_RES             = 1;
   localparam int         F_TRIG_TIMER           = 2;
   localparam int         F_PULSE1_TOGGLE        = 7;
   localparam int         F_PULSE0_TOGGLE        = 6;
   localparam int         F_PULSE0_RES_LSB       = 4;
   localparam int         F_PULSE0_DENSITY       = 3;
   localparam int         F_PULSE0_CLK_LSB       = 0;
   localparam int         F_READ_END_REFRESH     = 7;
   localparam int         F_PROC_REFRESH         = 6;
   localparam int         F_REF_ALWAYS_ON        = 5;
   localparam int         F_POWER_ON_CONVERT     = 4;

   // ********************************************************
   // pulse interface encodings
   // ********************************************************
   localparam int         RES_BASE_BITS          = 10;
   localparam int         RES_STEP_BITS          = 2;
   localparam logic [2:0] CLK_OFF                = 3'h0;
   localparam logic [2:0] CLK_OLF_1              = 3'h1;
   localparam logic [2:0] CLK_OLF_2              = 3'h2;
   localparam logic [2:0] CLK_OLF_4              = 3'h3;
   localparam logic [2:0] CLK_OX_1               = 3'h4;
   localparam logic [2:0] CLK_OX_2               = 3'h5;
   localparam logic [2:0] CLK_OX_4               = 3'h6;

   // ********************************************************
   // timing
   // ********************************************************
   localparam int         CLK_HZ                 = 40_000_000;
   localparam int         WD_PERIOD_S            = 12;
   localparam int         WD_CYCLES              = CLK_HZ * WD_PERIOD_S;
   localparam int         WD_CNT_W               = 29;
endpackage

// >>> verilog/pulse_if.sv
`timescale 1ns/10ps
interface pulse_if;
   logic        olf_tick;
   logic        ox_tick;
   logic [2:0]  clk_sel;
   logic [1:0]  res;
   logic        density;
   logic        toggle;
   logic [15:0] value;
   logic        out;
   modport ctrl (output olf_tick, ox_tick, clk_sel, res, density, toggle, value, input out);
   modport gen  (input olf_tick, ox_tick, clk_sel, res, density, toggle, value, output out);
endinterface

// >>> verilog/pulse_gen.sv
`timescale 1ns/10ps
module pulse_gen
   import cfg_bank_pkg::*;
(
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   pulse_if.gen      p
);
   logic [1:0]  div_cnt;
   logic        tick;
   logic [15:0] mask;
   logic [15:0] cnt;
   logic [15:0] acc;
   logic [16:0] sum;
   logic        raw;
   logic [4:0]  bits;

   // ********************************************************
   // clock select and prescale
   // ********************************************************
   logic src_tick;
   logic [1:0] div_mask;
   assign src_tick = (p.clk_sel inside {CLK_OLF_1, CLK_OLF_2, CLK_OLF_4}) ? p.olf_tick
                   : (p.clk_sel inside {CLK_OX_1, CLK_OX_2, CLK_OX_4}) ? p.ox_tick : 1'b0;
   assign div_mask = (p.clk_sel inside {CLK_OLF_2, CLK_OX_2}) ? 2'h1
                   : (p.clk_sel inside {CLK_OLF_4, CLK_OX_4}) ? 2'h3 : 2'h0;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         div_cnt <= 2'h0;
      end else if (src_tick) begin
         div_cnt <= div_cnt + 2'h1;
      end
   end
   assign tick = src_tick && ((div_cnt & div_mask) == 2'h0);

   // ********************************************************
   // resolution mask: 10, 12, 14 or 16 bits
   // ********************************************************
   assign bits = 5'(RES_BASE_BITS) + 5'(RES_STEP_BITS) * {3'h0, p.res};
   assign mask = 16'((17'h1 << bits) - 17'h1);

   // ********************************************************
   // pwm counter and pdm accumulator
   // ********************************************************
   assign sum = {1'b0, acc & mask} + {1'b0, p.value & mask};
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         cnt <= 16'h0000;
         acc <= 16'h0000;
      end else if (tick) begin
         cnt <= (cnt + 16'h0001) & mask;
         acc <= sum[15:0] & mask;
      end
   end

   // density select: 0 pwm, 1 pdm
   assign raw = p.density ? sum[bits] : ((cnt & mask) < (p.value & mask));

   // ********************************************************
   // output stage with optional toggle flip-flop
   // ********************************************************
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         p.out <= 1'b0;
      end else if (p.clk_sel == CLK_OFF) begin
         p.out <= 1'b0;
      end else if (tick) begin
         p.out <= p.toggle ? (p.out ^ raw) : raw;
      end
   end
endmodule

// >>> verilog/cfg_bank.sv
// Notes on behaviour
// - watchdog stops only while its disable register holds 0x5A; other values keep it running.
// - an enabled watchdog expires after a period between nine and fifteen seconds.
// - start-pin mask bits 7:4 let pins 0..3 start the processor, several at once.
// - bits 3:0 choose which of four processor inputs set their input latches.
// - bit 7 puts active-low irq on pin 5, bit 6 on pin 4; clear keeps normal.
// - trigger field starts processor on cap end, res end or timer, each enabled alone.
// - toggle enable bits pass pulse outputs 1 and 0 through a toggle flip-flop.
// - resolution code selects 10/12/14/16 bits; bit 3 picks pwm or pdm for output 0.
// - port bits 7:4 set pins 0..3 direction, 0 output and 1 input.
// - port bits 3:0 enable pull-ups on pins 0..3 when set.
// - bit 7 lets the end of a host read trigger a reference refresh.
// - bit 6 lets processor refresh requests through; clear ignores them.
// - bit 5 keeps the reference always on, else it runs pulsed.
// - power_on_convert bit issues one capacitance conversion trigger after power-on.
// - gain byte is a fraction for firmware, code n meaning 1 + n/256.
`timescale 1ns/10ps
module cfg_bank
   import cfg_bank_pkg::*;
#(
   parameter int WD_LIMIT = WD_CYCLES
)
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   // register port
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   output logic      [7:0]  reg_rdata_o,
   // watchdog
   input  wire logic        wd_kick_i,
   output logic             wd_expire_o,
   // processor start sources
   input  wire logic [3:0]  port_pin_i,
   input  wire logic [3:0]  proc_in_i,
   input  wire logic [3:0]  proc_in_clr_i,
   input  wire logic        cap_done_i,
   input  wire logic        res_done_i,
   input  wire logic        timer_evt_i,
   output logic             proc_start_o,
   output logic      [3:0]  proc_in_latch_o,
   // general purpose pins
   input  wire logic [5:0]  port_dout_i,
   input  wire logic [1:0]  port45_drive_i,
   input  wire logic        irq_n_i,
   output logic      [5:0]  port_pin_o,
   output logic      [5:0]  port_pin_oe_n_o,
   output logic      [3:0]  port_pullup_o,
   // pulse outputs
   input  wire logic        olf_tick_i,
   input  wire logic        ox_tick_i,
   input  wire logic [15:0] pulse0_value_i,
   input  wire logic        pulse1_raw_i,
   output logic             pulse0_o,
   output logic             pulse1_o,
   // reference and power_on_convert
   input  wire logic        read_done_i,
   input  wire logic        proc_refresh_req_i,
   input  wire logic        cfg_loaded_i,
   output logic             ref_refresh_o,
   output logic             ref_always_on_o,
   output logic             cap_start_o,
   output logic      [7:0]  gain_factor_o
);
   // ********************************************************
   // register storage
   // ********************************************************
   logic [7:0] watchdog_disable;
   logic [7:0] dsp_start_pin_masks;
   logic [7:0] interrupt_route_dsp_trigger;
   logic [7:0] pulse_out0_config;
   logic [7:0] pulse_out1_config;
   logic [7:0] port_direction_pullup;
   logic [7:0] bandgap_power_on_convert_control;
   logic [7:0] gain_correction;

   // register writes, one slot per offset
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         watchdog_disable            <= RST_ZERO;
         dsp_start_pin_masks         <= RST_ZERO;
         interrupt_route_dsp_trigger <= RST_ZERO;
         pulse_out0_config           <= RST_ZERO;
         pulse_out1_config           <= RST_ZERO;
         port_direction_pullup       <= RST_ZERO;
         bandgap_power_on_convert_control   <= RST_BANDGAP_POWER_ON_CONVERT;
         gain_correction             <= RST_GAIN_CORRECTION;
      end else if (reg_wr_i) begin
         unique case (reg_addr_i)
            OFS_WATCHDOG_DISABLE:  watchdog_disable            <= reg_wdata_i;
            OFS_DSP_START_PIN:     dsp_start_pin_masks         <= reg_wdata_i;
            OFS_IRQ_ROUTE_TRIGGER: interrupt_route_dsp_trigger <= reg_wdata_i;
            OFS_PULSE_OUT0_CONFIG: pulse_out0_config           <= reg_wdata_i;
            OFS_PULSE_OUT1_CONFIG: pulse_out1_config           <= reg_wdata_i;
            OFS_PORT_DIR_PULLUP:   port_direction_pullup       <= reg_wdata_i;
            OFS_BANDGAP_POWER_ON_CONVERT: bandgap_power_on_convert_control   <= reg_wdata_i;
            OFS_GAIN_CORRECTION:   gain_correction             <= reg_wdata_i;
            default: ;
         endcase
      end
   end

   // register read mux, registered
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= RST_ZERO;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            OFS_WATCHDOG_DISABLE:  reg_rdata_o <= watchdog_disable;
            OFS_DSP_START_PIN:     reg_rdata_o <= dsp_start_pin_masks;
            OFS_IRQ_ROUTE_TRIGGER: reg_rdata_o <= interrupt_route_dsp_trigger;
            OFS_PULSE_OUT0_CONFIG: reg_rdata_o <= pulse_out0_config;
            OFS_PULSE_OUT1_CONFIG: reg_rdata_o <= pulse_out1_config;
            OFS_PORT_DIR_PULLUP:   reg_rdata_o <= port_direction_pullup;
            OFS_BANDGAP_POWER_ON_CONVERT: reg_rdata_o <= bandgap_power_on_convert_control;
            OFS_GAIN_CORRECTION:   reg_rdata_o <= gain_correction;
            OFS_UNUSED_SLOT:       reg_rdata_o <= RST_ZERO;
            default:               reg_rdata_o <= RST_ZERO;
         endcase
      end
   end

   // ********************************************************
   // field decode
   // ********************************************************
   logic [3:0] proc_start_pin_mask;
   logic [3:0] proc_input_latch_mask;
   logic       irq_to_pin5;
   logic       irq_to_pin4;
   logic [3:0] port_direction;
   logic [3:0] port_pullup;

   assign proc_start_pin_mask   = dsp_start_pin_masks[F_HI_NIB_LSB +: 4];
   assign proc_input_latch_mask = dsp_start_pin_masks[3:0];
   assign irq_to_pin5           = interrupt_route_dsp_trigger[F_IRQ_TO_PIN5];
   assign irq_to_pin4           = interrupt_route_dsp_trigger[F_IRQ_TO_PIN4];
   assign port_direction        = port_direction_pullup[F_HI_NIB_LSB +: 4];
   assign port_pullup           = port_direction_pullup[3:0];

   // ********************************************************
   // watchdog
   // ********************************************************
   logic                wd_enabled;
   logic [WD_CNT_W-1:0] wd_cnt;
   localparam logic [WD_CNT_W-1:0] WD_LAST = WD_CNT_W'(WD_LIMIT - 1);

   assign wd_enabled = (watchdog_disable != WATCHDOG_OFF_KEY);

   // counts while enabled; kick or disable restarts it
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         wd_cnt      <= '0;
         wd_expire_o <= 1'b0;
      end else if (!wd_enabled || wd_kick_i) begin
         wd_cnt      <= '0;
         wd_expire_o <= 1'b0;
      end else if (wd_cnt == WD_LAST) begin
         wd_cnt      <= '0;
         wd_expire_o <= 1'b1;
      end else begin
         wd_cnt      <= wd_cnt + WD_CNT_W'(1);
         wd_expire_o <= 1'b0;
      end
   end

   // ********************************************************
   // pin synchronisers
   // ********************************************************
   logic [3:0] pin_meta;
   logic [3:0] pin_sync;
   logic [3:0] pin_prev;
   logic [3:0] in_meta;
   logic [3:0] in_sync;
   logic [3:0] in_prev;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pin_meta <= 4'h0;
         pin_sync <= 4'h0;
         pin_prev <= 4'h0;
         in_meta  <= 4'h0;
         in_sync  <= 4'h0;
         in_prev  <= 4'h0;
      end else begin
         pin_meta <= port_pin_i;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
         in_meta  <= proc_in_i;
         in_sync  <= in_meta;
         in_prev  <= in_sync;
      end
   end

   // ********************************************************
   // processor start and input latches
   // ********************************************************
   logic [3:0] pin_rise;
   logic [3:0] in_rise;
   logic       pin_start;
   logic       evt_start;

   assign pin_rise  = pin_sync & ~pin_prev;
   assign in_rise   = in_sync & ~in_prev;
   assign pin_start = |(pin_rise & proc_start_pin_mask);
   assign evt_start = (cap_done_i  && interrupt_route_dsp_trigger[F_TRIG_CAP])
                   || (res_done_i  && interrupt_route_dsp_trigger[F_TRIG_RES])
                   || (timer_evt_i && interrupt_route_dsp_trigger[F_TRIG_TIMER]);

   // registered OR of all start requests; requests in the same cycle give one pulse
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         proc_start_o <= 1'b0;
      end else begin
         proc_start_o <= pin_start || evt_start;
      end
   end

   // input latches, set wins over clear
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_latch
         always_ff @(posedge core_clk_i) begin
            if (!rst_n_i) begin
               proc_in_latch_o[gi] <= 1'b0;
            end else if (in_rise[gi] && proc_input_latch_mask[gi]) begin
               proc_in_latch_o[gi] <= 1'b1;
            end else if (proc_in_clr_i[gi]) begin
               proc_in_latch_o[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // ********************************************************
   // general purpose pin drive
   // ********************************************************
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         port_pin_o      <= 6'h3F;
         port_pin_oe_n_o <= 6'h3F;
         port_pullup_o   <= 4'h0;
      end else begin
         port_pin_o[3:0]      <= port_dout_i[3:0];
         port_pin_oe_n_o[3:0] <= port_direction;
         port_pullup_o        <= port_pullup;
         // irq routing overrides normal use of pins 4 and 5
         port_pin_o[4]      <= irq_to_pin4 ? irq_n_i : port_dout_i[4];
         port_pin_oe_n_o[4] <= irq_to_pin4 ? 1'b0 : ~port45_drive_i[0];
         port_pin_o[5]      <= irq_to_pin5 ? irq_n_i : port_dout_i[5];
         port_pin_oe_n_o[5] <= irq_to_pin5 ? 1'b0 : ~port45_drive_i[1];
      end
   end

   // ********************************************************
   // pulse interfaces
   // ********************************************************
   pulse_if pulse0_bus ();

   assign pulse0_bus.olf_tick = olf_tick_i;
   assign pulse0_bus.ox_tick  = ox_tick_i;
   assign pulse0_bus.clk_sel  = pulse_out0_config[F_PULSE0_CLK_LSB +: 3];
   assign pulse0_bus.res      = pulse_out0_config[F_PULSE0_RES_LSB +: 2];
   assign pulse0_bus.density  = pulse_out0_config[F_PULSE0_DENSITY];
   assign pulse0_bus.toggle   = pulse_out0_config[F_PULSE0_TOGGLE];
   assign pulse0_bus.value    = pulse0_value_i;

   pulse_gen u_pulse0 (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .p          (pulse0_bus)
   );

   // output 1: toggle flip-flop on rising edges of its raw stream
   logic pulse1_prev;
   logic pulse1_tff;
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pulse1_prev <= 1'b0;
         pulse1_tff  <= 1'b0;
         pulse1_o    <= 1'b0;
         pulse0_o    <= 1'b0;
      end else begin
         pulse1_prev <= pulse1_raw_i;
         if (pulse1_raw_i && !pulse1_prev) begin
            pulse1_tff <= ~pulse1_tff;
         end
         pulse1_o <= pulse_out0_config[F_PULSE1_TOGGLE] ? pulse1_tff : pulse1_raw_i;
         pulse0_o <= pulse0_bus.out;
      end
   end

   // ********************************************************
   // reference refresh, power_on_convert, gain
   // ********************************************************
   logic power_on_convert_done;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ref_refresh_o   <= 1'b0;
         ref_always_on_o <= 1'b0;
         gain_factor_o   <= RST_GAIN_CORRECTION;
      end else begin
         ref_refresh_o <= (read_done_i && bandgap_power_on_convert_control[F_READ_END_REFRESH])
                       || (proc_refresh_req_i && bandgap_power_on_convert_control[F_PROC_REFRESH]);
         ref_always_on_o <= bandgap_power_on_convert_control[F_REF_ALWAYS_ON];
         gain_factor_o   <= gain_correction;
      end
   end

   // single conversion trigger once configuration is loaded after power-on
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         power_on_convert_done <= 1'b0;
         cap_start_o    <= 1'b0;
      end else if (cfg_loaded_i && !power_on_convert_done) begin
         power_on_convert_done <= 1'b1;
         cap_start_o    <= bandgap_power_on_convert_control[F_POWER_ON_CONVERT];
      end else begin
         cap_start_o    <= 1'b0;
      end
   end
endmodule

// >>> test/cfg_bank_checker.sv
`timescale 1ns/10ps
module cfg_bank_checker
   import cfg_bank_pkg::*;
(
   input wire logic       core_clk_i,
   input wire logic       rst_n_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       wd_expire_o,
   input wire logic       irq_n_i,
   input wire logic [5:0] port_pin_o,
   input wire logic [5:0] port_pin_oe_n_o,
   input wire logic [3:0] port_pullup_o,
   input wire logic       read_done_i,
   input wire logic       proc_refresh_req_i,
   input wire logic       ref_refresh_o
);
   // ********************************************************
   // register mirror and properties
   // ********************************************************
   logic [7:0] sh [OFS_WATCHDOG_DISABLE:OFS_BANDGAP_POWER_ON_CONVERT];
   // mirror of written bytes
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         sh <= '{default: RST_ZERO};
         sh[OFS_BANDGAP_POWER_ON_CONVERT] <= RST_BANDGAP_POWER_ON_CONVERT;
      end else if (reg_wr_i && reg_addr_i inside {[8'h1C:8'h22]}) begin
         sh[reg_addr_i] <= reg_wdata_i;
      end
   end
   wire logic [7:0] key = sh[OFS_WATCHDOG_DISABLE];
   wire logic [7:0] rt  = sh[OFS_IRQ_ROUTE_TRIGGER];
   wire logic [7:0] pd  = sh[OFS_PORT_DIR_PULLUP];
   wire logic [7:0] bg  = sh[OFS_BANDGAP_POWER_ON_CONVERT];
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_key_held;
      key == WATCHDOG_OFF_KEY ##1 key == WATCHDOG_OFF_KEY;
   endsequence
   chk_wd_key_off: assert property (
      s_key_held |-> !wd_expire_o) else $error("watchdog expired while off");
   chk_wd_gap: assert property (
      wd_expire_o |=> !wd_expire_o [*8]) else $error("watchdog expired too soon");
   chk_unused_zero: assert property (
      reg_rd_i && reg_addr_i == OFS_UNUSED_SLOT |=> reg_rdata_o == RST_ZERO)
      else $error("unused slot read not zero");
   chk_irq_pin5: assert property (
      rt[F_IRQ_TO_PIN5] |=> port_pin_o[5] == $past(irq_n_i) && !port_pin_oe_n_o[5])
      else $error("pin5 irq route wrong");
   chk_irq_pin4: assert property (
      rt[F_IRQ_TO_PIN4] |=> port_pin_o[4] == $past(irq_n_i) && !port_pin_oe_n_o[4])
      else $error("pin4 irq route wrong");
   chk_pin_dir: assert property (
      1'b1 |=> port_pin_oe_n_o[3:0] == $past(pd[7:4])) else $error("pin direction wrong");
   chk_pin_pullup: assert property (
      1'b1 |=> port_pullup_o == $past(pd[3:0])) else $error("pullup wrong");
   chk_refresh_read: assert property (
      read_done_i && bg[F_READ_END_REFRESH] |=> ref_refresh_o) else $error("no refresh");
   chk_refresh_idle: assert property (
      !(read_done_i && bg[F_READ_END_REFRESH]) && !(proc_refresh_req_i && bg[F_PROC_REFRESH])
      |=> !ref_refresh_o) else $error("unexpected refresh");
endmodule
bind cfg_bank cfg_bank_checker chk_i (.*);

// >>> test/cfg_bank_bench.sv
`timescale 1ns/10ps
module cfg_bank_bench;
   import cfg_bank_pkg::*;
   localparam int LIM = 50;
   logic        core_clk_i = 1'b0;
   logic        rst_n_i    = 1'b0;
   logic        wr         = 1'b0;
   logic        rd         = 1'b0;
   logic        irq_n      = 1'b1;
   logic        ox         = 1'b0;
   logic        raw        = 1'b0;
   logic        b;
   logic [7:0]  ad         = 8'h00;
   logic [7:0]  wd         = 8'h00;
   logic [6:0]  ev         = 7'h00;
   logic [3:0]  pin        = 4'h0;
   logic [3:0]  pin_in     = 4'h0;
   logic [3:0]  clr        = 4'h0;
   logic [15:0] val        = 16'h0000;
   logic [7:0]  rdata, gf;
   logic [5:0]  po, oe;
   logic [3:0]  lat, pu;
   logic        wde, st, p0, p1, rf, aon, cs;
   int          mismatches = 0;
   int          n_compared = 0;
   int          n, c;
   // ********************************************************
   // clock, design and tasks
   // ********************************************************
   always #12.5 core_clk_i = ~core_clk_i;
   cfg_bank #(.WD_LIMIT(LIM)) DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(ad), .reg_wdata_i(wd), .reg_rdata_o(rdata),
      .wd_kick_i(ev[6]), .wd_expire_o(wde), .port_pin_i(pin), .proc_in_i(pin_in),
      .proc_in_clr_i(clr), .cap_done_i(ev[0]), .res_done_i(ev[1]), .timer_evt_i(ev[2]),
      .proc_start_o(st), .proc_in_latch_o(lat), .port_dout_i(6'h15), .port45_drive_i(2'h3),
      .irq_n_i(irq_n), .port_pin_o(po), .port_pin_oe_n_o(oe), .port_pullup_o(pu),
      .olf_tick_i(1'b0), .ox_tick_i(ox), .pulse0_value_i(val), .pulse1_raw_i(raw),
      .pulse0_o(p0), .pulse1_o(p1), .read_done_i(ev[3]), .proc_refresh_req_i(ev[4]),
      .cfg_loaded_i(ev[5]), .ref_refresh_o(rf), .ref_always_on_o(aon), .cap_start_o(cs),
      .gain_factor_o(gf));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge core_clk_i);
      #1;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      wr <= 1'b1;
      ad <= a;
      wd <= d;
      @(posedge core_clk_i);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk_i);
      rd <= 1'b1;
      ad <= a;
      @(posedge core_clk_i);
      rd <= 1'b0;
      #1 chk("rdata", e, rdata);
   endtask
   task automatic pulse(input int k);
      @(posedge core_clk_i);
      ev[k] <= 1'b1;
      @(posedge core_clk_i);
      ev[k] <= 1'b0;
      #1;
   endtask
   task automatic count_wde(input int lim);
      n = 0;
      while (wde !== 1'b1 && n < lim) begin
         step(1);
         n++;
      end
   endtask
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ********************************************************
   // scenarios
   // ********************************************************
   task automatic t_regs();
      chk("gain", 8'h40, gf);
      for (int a = 8'h1C; a <= 8'h24; a++) begin
         rreg(a[7:0], a == 8'h22 ? 8'h07 : a == 8'h23 ? 8'h40 : 8'h00);
         wreg(a[7:0], a[7:0] ^ 8'hA5);
         rreg(a[7:0], a == 8'h24 ? 8'h00 : a[7:0] ^ 8'hA5);
      end
      chk("gain", 8'h86, gf);
      $display("test regs done");
   endtask
   task automatic t_auto();
      wreg(OFS_BANDGAP_POWER_ON_CONVERT, 8'h17);
      pulse(5);
      chk("power_on_convert", 1, cs);
      pulse(5);
      chk("power_on_convert again", 0, cs);
      $display("test power_on_convert done");
   endtask
   task automatic t_wdog();
      wreg(OFS_WATCHDOG_DISABLE, 8'h00);
      pulse(6);
      count_wde(2 * LIM);
      chk("wd period", 1, n >= LIM - 3 && n <= LIM + 1);
      wreg(OFS_WATCHDOG_DISABLE, WATCHDOG_OFF_KEY);
      count_wde(3 * LIM);
      chk("wd off", 3 * LIM, n);
      wreg(OFS_WATCHDOG_DISABLE, 8'h5B);
      count_wde(2 * LIM);
      chk("wd on", 1, n < 2 * LIM);
      $display("test watchdog done");
   endtask
   task automatic t_start();
      for (int k = 0; k < 3; k++) begin
         wreg(OFS_IRQ_ROUTE_TRIGGER, 8'h01 << k);
         for (int e = 0; e < 3; e++) begin
            pulse(e);
            chk("start", e == k, st);
         end
      end
      wreg(OFS_DSP_START_PIN, 8'h41);
      pin <= 4'h4;
      step(3);
      chk("pin start", 1, st);
      pin <= 4'h6;
      pin_in <= 4'h3;
      step(4);
      chk("masked pin", 0, st);
      step(2);
      chk("latch", 4'h1, lat);
      @(posedge core_clk_i);
      clr <= 4'hF;
      step(1);
      clr <= 4'h0;
      step(1);
      chk("latch clear", 4'h0, lat);
      $display("test start done");
   endtask
   task automatic t_pins();
      wreg(OFS_IRQ_ROUTE_TRIGGER, 8'h00);
      wreg(OFS_PORT_DIR_PULLUP, 8'h5A);
      irq_n <= 1'b0;
      step(2);
      chk("dir", 8'h55, {po[3:0], oe[3:0]});
      chk("pullup", 4'hA, pu);
      chk("pin45 normal", 4'h4, {po[5:4], oe[5:4]});
      wreg(OFS_IRQ_ROUTE_TRIGGER, 8'hC0);
      step(2);
      chk("pin45 irq low", 4'h0, {po[5:4], oe[5:4]});
      wreg(OFS_IRQ_ROUTE_TRIGGER, 8'h80);
      irq_n <= 1'b1;
      step(2);
      chk("pin5 irq high", 4'hC, {po[5:4], oe[5:4]});
      $display("test pins done");
   endtask
   task automatic t_ref();
      for (int k = 0; k < 3; k++) begin
         wreg(OFS_BANDGAP_POWER_ON_CONVERT, 8'h80 >> k);
         pulse(3);
         chk("read refresh", k == 0, rf);
         pulse(4);
         chk("proc refresh", k == 1, rf);
         chk("always on", k == 2, aon);
      end
      $display("test refresh done");
   endtask
   task automatic t_pulse();
      @(posedge core_clk_i);
      val <= 16'h0200;
      ox <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         wreg(OFS_PULSE_OUT0_CONFIG, {2'b00, k[1:0], 4'hC});
         step(8);
         c = 0;
         repeat (512) begin
            step(1);
            c += int'(p0);
         end
         chk("pdm ones", 1, c >= (256 >> 2 * k) - 1 && c <= (256 >> 2 * k) + 1);
      end
      wreg(OFS_PULSE_OUT0_CONFIG, 8'h80);
      step(2);
      b = p1;
      @(posedge core_clk_i);
      raw <= 1'b1;
      step(3);
      chk("toggle", !b, p1);
      wreg(OFS_PULSE_OUT0_CONFIG, 8'h00);
      step(3);
      chk("raw", 1, p1);
      $display("test pulse done");
   endtask
   // reset, scenarios, verdict
   initial begin
      repeat (5) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      t_regs();
      t_auto();
      t_wdog();
      t_start();
      t_pins();
      t_ref();
      t_pulse();
      test_done();
   end
   // hang guard
   initial begin
      #(25 * 20000);
      mismatches++;
      test_done();
   end
endmodule
